// [sam_alert_top.sv]
// alert masking: sticky status, per-register masks, alert pin and alert response
// Functional notes
// - a status bit with mask 1 never drives the alert, one with mask 0 drives it active once it sets.
// - each mask is eight bits, 7 down to 0, each gating the status bit at the same position.
// - every mask is written through command 0x1B, the status code picks which mask.
// - one mask belongs to the output-voltage status register 0x7A and gates only its bits.
// - one mask belongs to the output-current status register 0x7B and gates only its bits.
// - one mask belongs to the input status register 0x7C and gates only its bits.
// - one mask belongs to the temperature status register 0x7D and gates only its bits.
// - one mask belongs to the communication/memory/logic status register 0x7E and gates only its bits.
// - a dedicated alert pin exists and the device answers the alert response with its address.
// - the clear-faults command 0x03 clears every status bit except those set in the same cycle, and releases the alert if none are set then.
`timescale 1ns/1ps
module sam_alert_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary default address
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_sel,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic [7:0] set_vout,
  input wire logic [7:0] set_iout,
  input wire logic [7:0] set_input,
  input wire logic [7:0] set_temp,
  input wire logic [7:0] set_cml,
  input wire logic ara_req,
  output logic ara_valid,
  output logic [7:0] ara_data,
  output logic alert_output_o,
  output logic alert_output_oe
);
  sam_mask_if mif ();
  sam_pkg::sam_bank_t status_r;
  sam_pkg::sam_bank_t status_nxt;
  sam_pkg::sam_bank_t set_bank;
  logic [sam_pkg::NUM_STATUS-1:0] pend_reg;
  logic alert_raw;
  logic new_unmasked;
  logic [2:0] code_idx;

  // alert service: armed, or answered and holding the pin off
  typedef enum logic {SVC_ARMED, SVC_ANSWERED} sam_svc_t;
  sam_svc_t svc_r;
  sam_svc_t svc_nxt;

  // pin flop and the mask view it is computed from
  sam_pkg::sam_bank_t mask_view_nxt;
  logic [sam_pkg::NUM_STATUS-1:0] pend_nxt;
  logic alert_oe_r;
  logic alert_oe_nxt;
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic [7:0] rsp_data_r;
  logic [7:0] rsp_data_nxt;
  logic ara_valid_r;
  logic ara_valid_nxt;
  logic [7:0] ara_data_r;
  logic [7:0] ara_data_nxt;
  logic clear_cmd;
  logic [2:0] sel_idx;

  sam_mask_bank u_bank (
    .clk(clk),
    .rst(rst),
    .mif(mif)
  );

  // event inputs arranged by bank index
  assign set_bank[sam_pkg::IDX_VOUT] = set_vout;
  assign set_bank[sam_pkg::IDX_IOUT] = set_iout;
  assign set_bank[sam_pkg::IDX_INPUT] = set_input;
  assign set_bank[sam_pkg::IDX_TEMP] = set_temp;
  assign set_bank[sam_pkg::IDX_CML] = set_cml;

  assign clear_cmd = cmd_valid && cmd_write && (cmd_code == sam_pkg::CMD_CLEAR_FAULTS);
  assign sel_idx = sam_pkg::sam_code_idx(cmd_sel);
  assign code_idx = sam_pkg::sam_code_idx(cmd_code);

  // mask write: command, then status code, then byte
  assign mif.wr_en = cmd_valid && cmd_write && (cmd_code == sam_pkg::CMD_ALERT_MASK);
  assign mif.wr_idx = sel_idx;
  assign mif.wr_data = cmd_wdata;

  // next mask view, mirroring the bank, so the pin flop costs no extra cycle
  always_comb
  begin
    mask_view_nxt = mif.masks;
    for (int i = 0; i < sam_pkg::NUM_STATUS; i++)
    begin
      if (mif.wr_en && (mif.wr_idx == 3'(i)))
        mask_view_nxt[i] = mif.wr_data;
    end
  end

  // sticky status; a set in the clear cycle survives so no event is lost
  always_comb
  begin
    for (int i = 0; i < sam_pkg::NUM_STATUS; i++)
    begin
      if (clear_cmd)
        status_nxt[i] = set_bank[i];
      else
        status_nxt[i] = status_r[i] | set_bank[i];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_r <= {sam_pkg::NUM_STATUS{sam_pkg::STATUS_RESET}};
    else
      status_r <= status_nxt;
  end

  // bitwise gating, each mask only sees its own register
  generate
    for (genvar g = 0; g < sam_pkg::NUM_STATUS; g++)
    begin : g_gate
      assign pend_reg[g] = |(status_r[g] & ~mif.masks[g]);
      assign pend_nxt[g] = |(status_nxt[g] & ~mask_view_nxt[g]);
    end
  endgenerate
  assign alert_raw = |pend_reg;

  // a fresh unmasked event re-arms the alert after an alert response
  always_comb
  begin
    new_unmasked = 1'b0;
    for (int i = 0; i < sam_pkg::NUM_STATUS; i++)
      new_unmasked = new_unmasked | (|(set_bank[i] & ~status_r[i] & ~mif.masks[i]));
  end

  // alert response: answer address with the write bit clear, then release the pin
  always_comb
  begin
    svc_nxt = svc_r;
    ara_valid_nxt = 1'b0;
    ara_data_nxt = ara_data_r;
    unique case (svc_r)
      SVC_ARMED:
      begin
        if (ara_req && alert_raw)
        begin
          ara_valid_nxt = 1'b1;
          ara_data_nxt = {DEV_ADDR, 1'b0};
          svc_nxt = SVC_ANSWERED;
        end
      end
      SVC_ANSWERED:
        svc_nxt = SVC_ANSWERED; // held until a fresh event, a clear or the cause going away
    endcase
    if (new_unmasked || clear_cmd || !alert_raw)
      svc_nxt = SVC_ARMED; // set-type event wins over the response release
    // the pin flop sees status and masks as they stand after this edge
    alert_oe_nxt = (|pend_nxt) && (svc_nxt == SVC_ARMED);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      svc_r <= SVC_ARMED;
      ara_valid_r <= 1'b0;
      ara_data_r <= sam_pkg::READ_NONE;
      alert_oe_r <= 1'b0;
    end
    else
    begin
      svc_r <= svc_nxt;
      ara_valid_r <= ara_valid_nxt;
      ara_data_r <= ara_data_nxt;
      alert_oe_r <= alert_oe_nxt;
    end
  end

  // reads: mask by status code, or the status register itself
  always_comb
  begin
    rsp_valid_nxt = cmd_valid && !cmd_write;
    rsp_data_nxt = rsp_data_r;
    if (cmd_valid && !cmd_write)
    begin
      rsp_data_nxt = sam_pkg::READ_NONE; // unknown code or selector reads zero
      if (cmd_code == sam_pkg::CMD_ALERT_MASK)
      begin
        if (sel_idx != sam_pkg::IDX_NONE)
          rsp_data_nxt = mif.masks[sel_idx];
      end
      else if (code_idx != sam_pkg::IDX_NONE)
        rsp_data_nxt = status_r[code_idx];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= sam_pkg::READ_NONE;
    end
    else
    begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign ara_valid = ara_valid_r;
  assign ara_data = ara_data_r;
  // open drain, active low: only ever drive zero
  assign alert_output_o = 1'b0;
  // from a flop: a glitch on the shared alert line would reach every host
  assign alert_output_oe = alert_oe_r;
endmodule // sam_alert_top

// [sam_pkg.sv]
// constants and types for the status alert masking block
package sam_pkg;
  localparam int unsigned NUM_STATUS = 5;
  localparam int unsigned BYTE_W = 8;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CODE_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] CODE_STATUS_IOUT = 8'h7B;
  localparam logic [7:0] CODE_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] CODE_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] CODE_STATUS_CML = 8'h7E;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [2:0] IDX_VOUT = 3'h0;
  localparam logic [2:0] IDX_IOUT = 3'h1;
  localparam logic [2:0] IDX_INPUT = 3'h2;
  localparam logic [2:0] IDX_TEMP = 3'h3;
  localparam logic [2:0] IDX_CML = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;
  typedef logic [7:0] sam_byte_t;
  typedef sam_byte_t [NUM_STATUS-1:0] sam_bank_t;

  // status command code to bank index, IDX_NONE when not a status code
  function automatic logic [2:0] sam_code_idx(input logic [7:0] code);
    logic [2:0] idx;
    idx = IDX_NONE;
    unique case (code)
      CODE_STATUS_VOUT: idx = IDX_VOUT;
      CODE_STATUS_IOUT: idx = IDX_IOUT;
      CODE_STATUS_INPUT: idx = IDX_INPUT;
      CODE_STATUS_TEMP: idx = IDX_TEMP;
      CODE_STATUS_CML: idx = IDX_CML;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction
endpackage

// [sam_mask_if.sv]
// carrier between the command decoder and the mask bank
`timescale 1ns/1ps
interface sam_mask_if;
  logic wr_en;
  logic [2:0] wr_idx;
  sam_pkg::sam_byte_t wr_data;
  sam_pkg::sam_bank_t masks;
  modport ctrl (output wr_en, output wr_idx, output wr_data, input masks);
  modport bank (input wr_en, input wr_idx, input wr_data, output masks);
endinterface

// [sam_mask_bank.sv]
// five 8-bit alert masks, one per status register
`timescale 1ns/1ps
module sam_mask_bank (
  input wire logic clk,
  input wire logic rst,
  sam_mask_if.bank mif
);
  sam_pkg::sam_bank_t mask_r;
  sam_pkg::sam_bank_t mask_nxt;

  // only the mask picked by the status code changes
  always_comb
  begin
    mask_nxt = mask_r;
    for (int i = 0; i < sam_pkg::NUM_STATUS; i++)
    begin
      if (mif.wr_en && (mif.wr_idx == 3'(i)))
        mask_nxt[i] = mif.wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask_r <= {sam_pkg::NUM_STATUS{sam_pkg::MASK_RESET}};
    else
      mask_r <= mask_nxt;
  end

  assign mif.masks = mask_r;
endmodule // sam_mask_bank

// [sam_alert_props.sv]
// assertions on the alert masking ports
`timescale 1ns/1ps
module sam_alert_props #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary default address
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic ara_req,
  input wire logic rsp_valid,
  input wire logic ara_valid,
  input wire logic alert_output_o,
  input wire logic alert_output_oe,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] ara_data,
  input wire logic [7:0] set_vout,
  input wire logic [7:0] set_iout,
  input wire logic [7:0] set_input,
  input wire logic [7:0] set_temp,
  input wire logic [7:0] set_cml
);
  logic any_set;
  // a fresh unmasked set in the same cycle wins over a clear or an alert response release
  assign any_set = |{set_vout, set_iout, set_input, set_temp, set_cml};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  pin_data_low_a: assert property (alert_output_o == 1'b0) else $error("pin data high");
  read_answer_a: assert property (cmd_valid && !cmd_write |=> rsp_valid) else $error("no answer");
  answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid && !cmd_write)) else $error("stray answer");
  ara_address_a: assert property (ara_valid |-> ara_data == {DEV_ADDR, 1'b0}) else $error("bad address");
  ara_cause_a: assert property (ara_valid |-> $past(ara_req && alert_output_oe)) else $error("stray ara");
  alert_cause_a: assert property ($rose(alert_output_oe) |->
    $past(any_set || cmd_valid && cmd_write && cmd_code == 8'h1B)) else $error("alert no cause");
  clear_release_a: assert property (cmd_valid && cmd_write && cmd_code == 8'h03 && !any_set
    |=> !alert_output_oe) else $error("clear kept alert");
  ara_release_a: assert property (ara_req && alert_output_oe && !any_set && !cmd_valid
    |=> ara_valid && !alert_output_oe) else $error("ara kept alert");
endmodule // sam_alert_props
bind sam_alert_top sam_alert_props #(.DEV_ADDR(DEV_ADDR)) u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .ara_req(ara_req), .rsp_valid(rsp_valid), .ara_valid(ara_valid),
  .alert_output_o(alert_output_o), .alert_output_oe(alert_output_oe), .cmd_code(cmd_code), .ara_data(ara_data),
  .set_vout(set_vout), .set_iout(set_iout), .set_input(set_input), .set_temp(set_temp), .set_cml(set_cml));

// [sam_host_model.sv]
// host model that services the alert by a response request
`timescale 1ns/1ps
module sam_host_model (
  input wire logic clk,
  input wire logic en,
  input wire logic alert_output_oe,
  input wire logic ara_valid,
  input wire logic [7:0] ara_data,
  output logic ara_req,
  output logic [7:0] got
);
  logic busy_r = 1'b0;
  logic req_r = 1'b0;
  logic [7:0] got_r = 8'h00;
  // one request per alert, busy until answered so no second pulse; answer taken while it stands
  always @(negedge clk)
  begin
    if (ara_valid)
    begin
      got_r <= ara_data;
      busy_r <= 1'b0;
    end
    else
      busy_r <= busy_r || (en && alert_output_oe);
    req_r <= en && alert_output_oe && !busy_r && !ara_valid;
  end
  assign ara_req = req_r;
  assign got = got_r;
endmodule // sam_host_model

// [sam_alert_top_tb.sv]
// self-checking bench for the alert masking block
`timescale 1ns/1ps
module sam_alert_top_tb;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary
  logic clk = 0;
  logic rst = 1;
  logic cmd_valid = 0;
  logic cmd_write = 0;
  logic host_en = 0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_sel = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] set_v [5] = '{default: 8'h00};
  logic rsp_valid, ara_valid, ara_req, pin_o, pin_oe;
  logic [7:0] rsp_data, ara_data, host_got, rd, m, v;
  int num_errors = 0;
  int compares = 0;
  int seed = 70;
  int b;
  always #4 clk = ~clk;
  sam_alert_top #(.DEV_ADDR(ADDR)) dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .set_vout(set_v[0]), .set_iout(set_v[1]), .set_input(set_v[2]), .set_temp(set_v[3]), .set_cml(set_v[4]),
    .ara_req(ara_req), .ara_valid(ara_valid), .ara_data(ara_data), .alert_output_o(pin_o), .alert_output_oe(pin_oe));
  sam_host_model host (.clk(clk), .en(host_en), .alert_output_oe(pin_oe), .ara_valid(ara_valid),
    .ara_data(ara_data), .ara_req(ara_req), .got(host_got));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one command every two cycles; the read answer stands one cycle later
  task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] sel, input logic [7:0] d);
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_code, cmd_sel, cmd_wdata} = {1'b1, w, code, sel, d};
    @(negedge clk);
    cmd_valid = 0;
    rd = rsp_data;
    chk("rsp_valid", {7'h0, rsp_valid}, {7'h0, !w});
  endtask
  task automatic pulse(input int i, input logic [7:0] bits);
    @(negedge clk);
    set_v[i] = bits;
    @(negedge clk);
    set_v[i] = 8'h00;
  endtask
  function automatic logic [7:0] code_of(input int i);
    return 8'h7A + 8'(i);
  endfunction
  function automatic logic [7:0] alert_of(input logic [7:0] st, input logic [7:0] mk);
    return {7'h0, |(st & ~mk)};
  endfunction
  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude;
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 0;
    // random masks and random status per register
    for (int i = 0; i < 5; i++)
    begin
      m = 8'($random(seed));
      v = 8'($random(seed));
      cmd(0, 8'h1B, code_of(i), 8'h00);
      chk("mask reset", rd, 8'h00);
      cmd(1, 8'h1B, code_of(i), m);
      cmd(0, 8'h1B, code_of(i), 8'h00);
      chk("mask", rd, m);
      pulse(i, v);
      chk("alert", {7'h0, pin_oe}, alert_of(v, m));
      cmd(1, 8'h03, 8'h00, 8'h00);
    end
    // one masked bit per register, then unmasked, then cleared
    for (int i = 0; i < 5; i++)
    begin
      b = {$random(seed)} % 8;
      m = 8'h01 << b;
      cmd(1, 8'h1B, code_of(i), m);
      pulse(i, m);
      chk("masked", {7'h0, pin_oe}, 8'h00);
      cmd(0, code_of(i), 8'h00, 8'h00);
      chk("status", rd, m);
      cmd(1, 8'h1B, code_of(i), ~m);
      chk("unmasked", {7'h0, pin_oe}, 8'h01);
      cmd(1, 8'h03, 8'h00, 8'h00);
      chk("cleared", {7'h0, pin_oe}, 8'h00);
    end
    // a set in the clear cycle survives the clear
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_code} = {1'b1, 1'b1, 8'h03};
    set_v[1] = 8'h04;
    @(negedge clk);
    cmd_valid = 0;
    set_v[1] = 8'h00;
    cmd(0, 8'h7B, 8'h00, 8'h00);
    chk("set in clear", rd, 8'h04);
    cmd(1, 8'h03, 8'h00, 8'h00);
    cmd(1, 8'h1B, 8'h7F, 8'hFF);
    cmd(0, 8'h1B, 8'h7F, 8'h00);
    chk("bad sel", rd, 8'h00);
    // host services a temperature alert
    cmd(1, 8'h1B, 8'h7D, 8'h00);
    host_en = 1;
    pulse(3, 8'h01);
    for (int k = 0; k < 10 && host_got === 8'h00; k++)
      @(negedge clk);
    chk("ara", host_got, {ADDR, 1'b0});
    chk("released", {7'h0, pin_oe}, 8'h00);
    chk("pin data", {7'h0, pin_o}, 8'h00);
    // a fresh unmasked bit re-arms the pin after the answer
    pulse(3, 8'h02);
    chk("rearmed", {7'h0, pin_oe}, 8'h01);
    repeat (2) @(negedge clk);
    chk("rereleased", {7'h0, pin_oe}, 8'h00);
    conclude;
  end
endmodule // sam_alert_top_tb
